//--- common/cpt_pkg.sv
// Package with register map, field layout, reset values and counts for the clock prescaler block.
package cpt_pkg;
    localparam logic [7:0] CPT_DIVIDE_CONTROL_INDEX = 8'h26;
    localparam logic [7:0] CPT_TRIM_INDEX = 8'h31;
    localparam logic [9:0] CPT_DIVIDE_CONTROL_ADDR = {CPT_DIVIDE_CONTROL_INDEX, 2'b00};
    localparam logic [9:0] CPT_TRIM_ADDR = {CPT_TRIM_INDEX, 2'b00};
    localparam int CPT_CHANGE_ENABLE_BIT = 7;
    localparam int CPT_SELECT_MSB = 3;
    localparam logic [7:0] CPT_CHANGE_ENABLE_WRITE = 8'h80;
    localparam logic [3:0] CPT_SELECT_RESET_DIV1 = 4'h0;
    localparam logic [3:0] CPT_SELECT_RESET_DIV8 = 4'h3;
    localparam logic [3:0] CPT_SELECT_MAX = 4'h8;
    localparam logic [7:0] CPT_TRIM_FACTORY_DEFAULT = 8'h0040;
    localparam logic [2:0] CPT_WINDOW_CYCLES = 3'h4;
    localparam logic [7:0] CPT_DIVIDER_ALL_ONES = 8'h00FF;

    typedef struct packed {
        logic [29:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } cpt_wb_req_type;

    typedef enum logic [1:0] {
        CPT_WIN_IDLE = 2'b00,
        CPT_WIN_OPEN = 2'b01
    } cpt_window_state_type;
endpackage

//--- src/cpt_divider.sv
// Power-of-two clock enable divider that changes rate only at a common boundary.
`timescale 1ns/100ps
module cpt_divider
    import cpt_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [3:0] i_select,
    output logic o_tick
);
    logic [7:0] count;
    logic [3:0] active_select;
    logic [7:0] mask;
    wire logic wrap;
    wire logic [3:0] clamped;

    // Reserved codes behave as the largest factor, 256.
    assign clamped = (i_select > CPT_SELECT_MAX) ? CPT_SELECT_MAX : i_select;
    assign mask = (active_select == CPT_SELECT_MAX) ? CPT_DIVIDER_ALL_ONES :
        8'((9'h001 << active_select) - 9'h001);
    assign wrap = ((count & mask) == mask);

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= 8'h0000;
            active_select <= 4'h0;
            o_tick <= 1'b0;
        end else begin
            // New rate takes effect only at the end of a whole old period.
            o_tick <= wrap;
            if (wrap) begin
                count <= 8'h0000;
                active_select <= clamped;
            end else begin
                count <= 8'(count + 8'h0001);
            end
        end
    end
endmodule // cpt_divider

//--- src/cpt_clock_prescaler.sv
// Clock prescaler with protected change sequence and oscillator trim register.
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/100ps
module cpt_clock_prescaler
    import cpt_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_initial_div8_fuse,
    input wire logic [7:0] i_trim_factory,
    input wire logic [29:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    input wire logic i_wb_we,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    output logic [7:0] o_oscillator_trim,
    output logic [3:0] o_divide_select,
    output logic o_system_clock_enable
);
    cpt_wb_req_type req;
    cpt_window_state_type window_state;
    cpt_window_state_type next_window_state;
    logic [2:0] window_count;
    logic [2:0] next_window_count;
    logic [3:0] divide_select;
    logic divide_change_enable;
    logic [7:0] oscillator_trim;
    logic loaded;
    logic divider_tick;
    wire logic access;
    wire logic write_strobe;
    wire logic hit_control;
    wire logic hit_trim;
    wire logic lane0;
    wire logic write_control;
    wire logic write_trim;
    wire logic enable_write;
    wire logic select_write;
    wire logic window_expired;
    wire logic [7:0] control_read;
    wire logic [31:0] read_data;

    assign req = '{adr: i_wb_adr, dat: i_wb_dat, sel: i_wb_sel, we: i_wb_we,
        cyc: i_wb_cyc, stb: i_wb_stb};
    assign access = req.cyc && req.stb && !o_wb_ack;
    assign write_strobe = access && req.we;
    assign hit_control = ({req.adr, 2'b00} == {22'h00_0000, CPT_DIVIDE_CONTROL_ADDR});
    assign hit_trim = ({req.adr, 2'b00} == {22'h00_0000, CPT_TRIM_ADDR});
    assign lane0 = req.sel[0];
    assign write_control = write_strobe && hit_control && lane0;
    assign write_trim = write_strobe && hit_trim && lane0;
    assign enable_write = write_control &&
        (req.dat[7:0] == CPT_CHANGE_ENABLE_WRITE);
    assign select_write = write_control && !req.dat[CPT_CHANGE_ENABLE_BIT];
    assign window_expired = (window_state == CPT_WIN_OPEN) &&
        (window_count == CPT_WINDOW_CYCLES - 3'h1);
    assign control_read = {divide_change_enable, 3'b000, divide_select};
    assign read_data = hit_control ? {24'h00_0000, control_read} :
        hit_trim ? {24'h00_0000, oscillator_trim} : 32'h0000_0000;

    always_comb begin
        next_window_state = window_state;
        next_window_count = window_count;
        case (window_state)
            CPT_WIN_IDLE: begin
                if (enable_write) begin
                    next_window_state = CPT_WIN_OPEN;
                    next_window_count = 3'h0;
                end
            end
            CPT_WIN_OPEN: begin
                // A repeated enable write does not restart the count.
                next_window_count = 3'(window_count + 3'h1);
                if (select_write || window_expired) begin
                    next_window_state = CPT_WIN_IDLE;
                    next_window_count = 3'h0;
                end
            end
            default: begin
                next_window_state = CPT_WIN_IDLE;
                next_window_count = 3'h0;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            window_state <= CPT_WIN_IDLE;
            window_count <= 3'h0;
            divide_change_enable <= 1'b0;
        end else begin
            window_state <= next_window_state;
            window_count <= next_window_count;
            divide_change_enable <= (next_window_state == CPT_WIN_OPEN);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            loaded <= 1'b0;
            divide_select <= CPT_SELECT_RESET_DIV1;
            oscillator_trim <= CPT_TRIM_FACTORY_DEFAULT;
        end else if (!loaded) begin
            // Fuse and factory trim are captured on the first edge after release.
            loaded <= 1'b1;
            divide_select <= i_initial_div8_fuse ? CPT_SELECT_RESET_DIV8 :
                CPT_SELECT_RESET_DIV1;
            oscillator_trim <= i_trim_factory;
        end else begin
            if (select_write && window_state == CPT_WIN_OPEN) begin
                divide_select <= req.dat[CPT_SELECT_MSB:0];
            end
            if (write_trim) begin
                oscillator_trim <= req.dat[7:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
            o_oscillator_trim <= CPT_TRIM_FACTORY_DEFAULT;
            o_divide_select <= CPT_SELECT_RESET_DIV1;
            o_system_clock_enable <= 1'b0;
        end else begin
            o_wb_ack <= access;
            o_wb_dat <= access ? read_data : 32'h0000_0000;
            o_oscillator_trim <= oscillator_trim;
            o_divide_select <= divide_select;
            o_system_clock_enable <= divider_tick && loaded;
        end
    end

    cpt_divider u_divider (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_select(divide_select),
        .o_tick(divider_tick)
    );

    a_enable_only_exact: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (write_control && req.dat[7:0] != CPT_CHANGE_ENABLE_WRITE && !divide_change_enable)
        |=> !divide_change_enable)
        else $error("Change enable set by a write other than 0x80.");

    a_window_four_cycles: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(divide_change_enable) |-> ##4 !divide_change_enable)
        else $error("Change enable did not clear after four cycles.");

    a_window_no_extend: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        ($rose(divide_change_enable) ##2 enable_write)
        |=> divide_change_enable ##1 !divide_change_enable)
        else $error("Repeated enable write extended the window.");

    a_select_protected: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (loaded && !divide_change_enable && $past(loaded)) |=> $stable(divide_select))
        else $error("Select changed outside the change window.");

    a_select_clears_enable: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (select_write && divide_change_enable) |=> !divide_change_enable)
        else $error("Select write did not clear change enable.");

    a_reserved_read_zero: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (access && !req.we && hit_control) |=> (o_wb_ack && o_wb_dat[6:4] == 3'b000))
        else $error("Reserved control bits read nonzero.");

    a_fuse_reset_value: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (!loaded && i_reset_n && i_initial_div8_fuse)
        |=> (divide_select == CPT_SELECT_RESET_DIV8))
        else $error("Fuse did not load divide by eight.");

    a_trim_write_lands: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (write_trim && loaded) |=> ##1 (o_oscillator_trim == $past(req.dat[7:0], 2)))
        else $error("Trim write did not reach the output.");

    a_div1_every_cycle: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_system_clock_enable && $past(divide_select, 2) == 4'h0)
        |=> o_system_clock_enable)
        else $error("Divide by one did not give an enable every cycle.");

    a_trim_factory_load: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (!loaded && i_reset_n)
        |=> (oscillator_trim == $past(i_trim_factory)))
        else $error("Factory trim was not loaded after reset.");

    a_fuse_clear_value: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (!loaded && i_reset_n && !i_initial_div8_fuse)
        |=> (divide_select == CPT_SELECT_RESET_DIV1))
        else $error("Clear fuse did not load divide by one.");

    a_trim_write_only: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (loaded && !write_trim)
        |=> $stable(oscillator_trim))
        else $error("Trim changed without a write.");

    a_control_read: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (access && !req.we && hit_control)
        |=> (o_wb_dat == {24'h00_0000, $past(divide_change_enable), 3'b000,
        $past(divide_select)}))
        else $error("Control read data is wrong.");

    a_trim_read: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (access && !req.we && hit_trim)
        |=> (o_wb_dat == {24'h00_0000, $past(oscillator_trim)}))
        else $error("Trim read data is wrong.");

    a_enable_sets: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (enable_write && !divide_change_enable)
        |=> divide_change_enable)
        else $error("Exact enable write did not set change enable.");

    a_enable_from_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        $rose(divide_change_enable)
        |-> $past(enable_write))
        else $error("Change enable rose without an exact enable write.");

    a_window_full: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        ($rose(divide_change_enable) && !select_write) ##1 !select_write ##1 !select_write
        |=> divide_change_enable)
        else $error("Change window closed before four cycles.");

    a_select_lands: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (select_write && divide_change_enable)
        |=> (divide_select == $past(req.dat[CPT_SELECT_MSB:0])))
        else $error("Select write inside the window did not land.");

    a_select_bit7_kept: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (write_control && req.dat[CPT_CHANGE_ENABLE_BIT] && loaded)
        |=> $stable(divide_select))
        else $error("Select changed on a write with enable bit set.");

    a_rewrite_keeps: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (enable_write && divide_change_enable && !window_expired)
        |=> divide_change_enable)
        else $error("Repeated enable write cleared the flag.");

    a_tick_single: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_system_clock_enable && $past(divide_select, 2) != 4'h0)
        |=> !o_system_clock_enable)
        else $error("Enable pulse longer than one cycle.");

    a_div2_period: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_system_clock_enable && $past(divide_select, 2) == 4'h1)
        |=> !o_system_clock_enable ##1 o_system_clock_enable)
        else $error("Divide by two period is wrong.");

    a_div4_period: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_system_clock_enable && $past(divide_select, 2) == 4'h2)
        |=> !o_system_clock_enable [*3] ##1 o_system_clock_enable)
        else $error("Divide by four period is wrong.");

    a_div8_period: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_system_clock_enable && $past(divide_select, 2) == 4'h3)
        |=> !o_system_clock_enable [*7] ##1 o_system_clock_enable)
        else $error("Divide by eight period is wrong.");

    a_gap_min_four: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_system_clock_enable && $past(divide_select, 2) >= 4'h2)
        |=> !o_system_clock_enable [*3])
        else $error("Enable period shorter than four cycles.");

    a_gap_min_eight: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (o_system_clock_enable && $past(divide_select, 2) >= 4'h3)
        |=> !o_system_clock_enable [*7])
        else $error("Enable period shorter than eight cycles.");

    a_enable_gated: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        !loaded
        |=> !o_system_clock_enable)
        else $error("System enable pulsed before capture.");

    a_trim_range_bit: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (write_trim && loaded)
        |=> (oscillator_trim[7] == $past(req.dat[7])))
        else $error("Trim range bit not stored.");

    a_trim_fine_bits: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (write_trim && loaded)
        |=> (oscillator_trim[6:0] == $past(req.dat[6:0])))
        else $error("Trim fine bits not stored.");

    a_trim_lane_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (write_strobe && hit_trim && !lane0 && loaded)
        |=> $stable(oscillator_trim))
        else $error("Trim written without lane zero enabled.");

    a_control_lane_gate: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
        (write_strobe && hit_control && !lane0 && loaded)
        |=> ($stable(divide_select) && !$rose(divide_change_enable)))
        else $error("Control written without lane zero enabled.");
endmodule // cpt_clock_prescaler

//--- tb/tb_cpt_clock_prescaler.sv
// Self-checking testbench for the clock prescaler and trim register block.
`timescale 1ns/100ps
module tb_cpt_clock_prescaler;
    import cpt_pkg::*;
    logic clk, rst_n, fuse, we, cyc, stb, ack, tick;
    logic [7:0] factory, o_trim;
    logic [29:0] adr;
    logic [31:0] wdat, rdat, o_dat;
    logic [3:0] sel, o_sel, cur;
    int err_total, total_checks;
    cpt_clock_prescaler i_cpt_clock_prescaler (.i_ref_clk(clk), .i_reset_n(rst_n),
        .i_initial_div8_fuse(fuse), .i_trim_factory(factory), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(sel), .i_wb_we(we), .i_wb_cyc(cyc), .i_wb_stb(stb), .o_wb_dat(o_dat),
        .o_wb_ack(ack), .o_oscillator_trim(o_trim), .o_divide_select(o_sel),
        .o_system_clock_enable(tick));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic summarize();
        if (err_total == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic [7:0] idx, input logic w, input logic [7:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge clk);
        adr <= {22'h0, idx};
        wdat <= {24'h0, d};
        we <= w;
        sel <= s;
        cyc <= 1'b1;
        stb <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = o_dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic rd_ctrl(input logic [7:0] exp);
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b0, 8'h00, 4'h1);
        chk(rdat, {24'h0, exp});
    endtask
    task automatic do_reset(input logic f, input logic [7:0] t);
        @(posedge clk);
        rst_n <= 1'b0;
        fuse <= f;
        factory <= t;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        cur = f ? CPT_SELECT_RESET_DIV8 : CPT_SELECT_RESET_DIV1;
        chk({24'h0, o_trim}, {24'h0, t});
        chk({28'h0, o_sel}, {28'h0, cur});
        rd_ctrl({4'h0, cur});
    endtask
    task automatic t_trim();
        wb(CPT_TRIM_INDEX, 1'b1, 8'h70, 4'h1);
        wb(CPT_TRIM_INDEX, 1'b1, 8'h7F, 4'h1);
        wb(CPT_TRIM_INDEX, 1'b0, 8'h00, 4'h1);
        chk(rdat, 32'h0000_007F);
        wb(CPT_TRIM_INDEX, 1'b1, 8'h80, 4'h1);
        wb(CPT_TRIM_INDEX, 1'b1, 8'h11, 4'h0);
        chk({24'h0, o_trim}, 32'h0000_0080);
        wb(8'h10, 1'b1, 8'hFF, 4'h1);
        wb(8'h10, 1'b0, 8'h00, 4'h1);
        chk(rdat, 32'h0000_0000);
    endtask
    task automatic t_enable();
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, CPT_CHANGE_ENABLE_WRITE, 4'h0);
        rd_ctrl({4'h0, cur});
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, 8'h81, 4'h1);
        rd_ctrl({4'h0, cur});
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, CPT_CHANGE_ENABLE_WRITE, 4'h1);
        rd_ctrl({4'h8, cur});
        rd_ctrl({4'h0, cur});
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, 8'h05, 4'h1);
        rd_ctrl({4'h0, cur});
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, CPT_CHANGE_ENABLE_WRITE, 4'h1);
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, CPT_CHANGE_ENABLE_WRITE, 4'h1);
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, 8'h02, 4'h1);
        rd_ctrl({4'h0, cur});
    endtask
    task automatic gap(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (tick !== 1'b1 && c < 600);
        if (c >= 600) begin
            err_total++;
            summarize();
        end
    endtask
    task automatic t_period(input logic [3:0] n);
        int c, po, pn;
        po = (cur > 8) ? 256 : (1 << cur);
        pn = (n > 8) ? 256 : (1 << n);
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, CPT_CHANGE_ENABLE_WRITE, 4'h1);
        wb(CPT_DIVIDE_CONTROL_INDEX, 1'b1, {4'h0, n}, 4'h1);
        cur = n;
        gap(c);
        gap(c);
        chk(c >= ((po < pn) ? po : pn), 1);
        gap(c);
        chk(c, pn);
        chk({28'h0, o_sel}, {28'h0, n});
        rd_ctrl({4'h0, n});
    endtask
    initial begin
        rst_n = 1'b0;
        fuse = 1'b1;
        factory = 8'h5A;
        adr = '0;
        wdat = '0;
        sel = 4'h0;
        we = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        err_total = 0;
        total_checks = 0;
        do_reset(1'b1, 8'h5A);
        t_trim();
        t_enable();
        for (int k = 0; k <= 9; k++) begin
            t_period(4'(k));
        end
        t_period(4'h1);
        do_reset(1'b0, 8'hA5);
        t_enable();
        t_period(4'h8);
        summarize();
    end
endmodule // tb_cpt_clock_prescaler
